// ---- common/imu_pkg.sv ----
package imu_pkg;
    // Instruction fields
    localparam logic [5:0] OPC_SPECIAL = 6'h00;
    localparam logic [5:0] OPC_SPECIAL2 = 6'h1C;
    localparam logic [5:0] FN_SIGNED_MUL = 6'h18;
    localparam logic [5:0] FN_UNSIGNED_MUL = 6'h19;
    localparam logic [5:0] FN_THREE_OP_MUL = 6'h02;
    localparam logic [5:0] FN_UPPER_WRITE = 6'h11;
    localparam logic [5:0] FN_BOTTOM_WRITE = 6'h13;
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int ZERO_HI = 15;
    localparam int ZERO_LO = 6;
    localparam int RD_HI = 15;
    localparam int RD_LO = 11;
    // Reset values
    localparam logic [31:0] PRODUCT_RST = 32'h0000_0000;
    // Latency: one cycle per significant 8-bit slice of source b
    localparam int SLICE_W = 8;

    typedef enum logic [2:0] {
        IMU_OP_NONE,
        IMU_OP_SIGNED,
        IMU_OP_UNSIGNED,
        IMU_OP_THREE,
        IMU_OP_UPPER_WR,
        IMU_OP_BOTTOM_WR
    } imu_op_e;

    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] source_a;
        logic [31:0] source_b;
    } imu_issue_s;

    typedef struct packed {
        logic valid;
        logic [4:0] dest;
        logic [31:0] data;
    } imu_gpr_wr_s;
endpackage : imu_pkg

// ---- rtl/imu_top.sv ----
`timescale 1ns/1ps
module imu_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Issue
    input wire logic issue_valid,
    input wire imu_pkg::imu_issue_s issue,
    output logic issue_ready,
    // Result read interlock
    input wire logic rd_upper,
    input wire logic rd_bottom,
    input wire logic rd_gpr,
    input wire logic [4:0] rd_gpr_index,
    output logic read_stall,
    // Results
    output logic [31:0] upper_product_word,
    output logic [31:0] bottom_product_word,
    output imu_pkg::imu_gpr_wr_s gpr_wr,
    output logic busy
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    typedef enum logic [1:0] {IMU_IDLE, IMU_RUN} imu_state_e;

    wire logic [5:0] opc = issue.instr[imu_pkg::OPC_HI:imu_pkg::OPC_LO];
    wire logic [5:0] fn = issue.instr[5:0];
    wire logic zero_ok = issue.instr[imu_pkg::ZERO_HI:imu_pkg::ZERO_LO] == 10'h000;
    wire logic is_special = opc == imu_pkg::OPC_SPECIAL;
    wire logic dec_signed = is_special && fn == imu_pkg::FN_SIGNED_MUL && zero_ok;
    wire logic dec_unsigned = is_special && fn == imu_pkg::FN_UNSIGNED_MUL && zero_ok;
    wire logic dec_three = opc == imu_pkg::OPC_SPECIAL2 && fn == imu_pkg::FN_THREE_OP_MUL;
    wire logic dec_upper = is_special && fn == imu_pkg::FN_UPPER_WRITE;
    wire logic dec_bottom = is_special && fn == imu_pkg::FN_BOTTOM_WRITE;
    wire logic dec_mul = dec_signed || dec_unsigned || dec_three;

    // ----------------------------------------
    // State
    // ----------------------------------------
    imu_state_e state_r, state_nxt;
    imu_pkg::imu_op_e op_r;
    logic [63:0] prod_r;
    logic [2:0] count_r, count_nxt;
    logic [4:0] dest_r;
    logic [31:0] upper_r, bottom_r;
    imu_pkg::imu_gpr_wr_s gpr_wr_r;

    // Slow path would stall issue; here one multiply runs at a time
    assign issue_ready = state_r == IMU_IDLE;
    wire logic start = issue_valid && issue_ready;

    // Full product taken at issue; the delay only models data-dependent latency
    wire logic signed [63:0] prod_s = $signed(issue.source_a) * $signed(issue.source_b);
    wire logic [63:0] prod_u = {32'h0000_0000, issue.source_a} * {32'h0000_0000, issue.source_b};
    wire logic [63:0] prod_sel = dec_unsigned ? prod_u : 64'(prod_s);

    // Significant slices of source b set the wait: a small b finishes early
    wire logic [2:0] lat = (issue.source_b[31:24] != 8'h00) ? 3'h4 :
                           (issue.source_b[23:16] != 8'h00) ? 3'h3 :
                           (issue.source_b[15:8] != 8'h00) ? 3'h2 : 3'h1;
    wire logic done = state_r == IMU_RUN && count_r == 3'h1;

    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        case (state_r)
            IMU_IDLE: begin
                if (start && dec_mul) begin
                    state_nxt = IMU_RUN;
                    count_nxt = lat;
                end
            end
            IMU_RUN: begin
                count_nxt = count_r - 3'h1;
                if (done) begin
                    state_nxt = IMU_IDLE;
                end
            end
            default: begin
                state_nxt = IMU_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= IMU_IDLE;
            count_r <= 3'h0;
            op_r <= imu_pkg::IMU_OP_NONE;
            prod_r <= 64'h0;
            dest_r <= 5'h00;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            if (start && dec_mul) begin
                prod_r <= prod_sel;
                dest_r <= issue.instr[imu_pkg::RD_HI:imu_pkg::RD_LO];
                op_r <= dec_three ? imu_pkg::IMU_OP_THREE :
                        dec_unsigned ? imu_pkg::IMU_OP_UNSIGNED : imu_pkg::IMU_OP_SIGNED;
            end
        end
    end

    // ----------------------------------------
    // Result registers
    // ----------------------------------------
    // No exception or overflow output exists at all
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            upper_r <= imu_pkg::PRODUCT_RST;
            bottom_r <= imu_pkg::PRODUCT_RST;
            gpr_wr_r <= '0;
        end else begin
            gpr_wr_r.valid <= 1'b0;
            if (done && op_r != imu_pkg::IMU_OP_THREE) begin
                upper_r <= prod_r[63:32];
                bottom_r <= prod_r[31:0];
            end else if (done) begin
                // Product pair left as-is: contents undefined after this op
                gpr_wr_r.valid <= 1'b1;
                gpr_wr_r.dest <= dest_r;
                gpr_wr_r.data <= prod_r[31:0];
            end else if (start && dec_upper) begin
                upper_r <= issue.source_a;
            end else if (start && dec_bottom) begin
                bottom_r <= issue.source_a;
            end
        end
    end

    assign upper_product_word = upper_r;
    assign bottom_product_word = bottom_r;
    assign gpr_wr = gpr_wr_r;
    assign busy = state_r == IMU_RUN;

    // ----------------------------------------
    // Interlock
    // ----------------------------------------
    wire logic pend_pair = busy && op_r != imu_pkg::IMU_OP_THREE;
    wire logic pend_gpr = busy && op_r == imu_pkg::IMU_OP_THREE;
    assign read_stall = (pend_pair && (rd_upper || rd_bottom)) ||
                        (pend_gpr && rd_gpr && rd_gpr_index == dest_r);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    stall_pair_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (busy && op_r != imu_pkg::IMU_OP_THREE && rd_upper) |-> read_stall)
        else $error("pair read not stalled");
    latency_max_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_mul) |-> ##[1:4] done)
        else $error("multiply latency exceeded");
    small_b_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_mul && issue.source_b[31:8] == 24'h0) |=> done)
        else $error("short operand not fast");
    signed_res_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_signed) |-> ##[1:4] (done ##1 ({upper_r, bottom_r} == $past(prod_r))))
        else $error("signed product wrong");
    gpr_wr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (done && op_r == imu_pkg::IMU_OP_THREE) |=> (gpr_wr.valid && gpr_wr.data == $past(prod_r[31:0])))
        else $error("three-operand result missing");
    upper_wr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_upper) |=> upper_product_word == $past(issue.source_a))
        else $error("upper write lost");
    bottom_wr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_bottom) |=> bottom_product_word == $past(issue.source_a))
        else $error("bottom write lost");
    zero_field_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (issue.instr[imu_pkg::ZERO_HI:imu_pkg::ZERO_LO] != 10'h000) |-> !(dec_signed || dec_unsigned))
        else $error("nonzero field accepted");
    no_lost_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        busy |-> !issue_ready)
        else $error("issue accepted while busy");

    // ----------------------------------------
    // Interlock and datapath checks
    // ----------------------------------------
    // A stale read of either half would break program results, so both halves are watched
    stall_bottom_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (busy && op_r != imu_pkg::IMU_OP_THREE && rd_bottom) |-> read_stall)
        else $error("bottom read not stalled");
    stall_gpr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (pend_gpr && rd_gpr && rd_gpr_index == dest_r) |-> read_stall)
        else $error("general register read not stalled");
    idle_stall_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !busy |-> !read_stall)
        else $error("stall raised while idle");
    run_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_mul) |=> busy)
        else $error("multiply did not start");
    other_ignored_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && !dec_mul) |=> !busy)
        else $error("non-multiply started a run");
    count_range_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        busy |-> (count_r != 3'h0 && count_r <= 3'h4))
        else $error("latency counter out of range");
    long_b_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_mul && issue.source_b[31:24] != 8'h00) |-> ##4 done)
        else $error("wide operand latency wrong");
    signed_cap_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_signed) |=>
        $signed(prod_r) == $signed($past(issue.source_a)) * $signed($past(issue.source_b)))
        else $error("signed capture wrong");
    unsigned_cap_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_unsigned) |=>
        prod_r == {32'h0000_0000, $past(issue.source_a)} * {32'h0000_0000, $past(issue.source_b)})
        else $error("unsigned capture wrong");
    pair_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (done && op_r != imu_pkg::IMU_OP_THREE) |=>
        {upper_product_word, bottom_product_word} == $past(prod_r))
        else $error("product pair not written");
    no_gpr_pair_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (done && op_r != imu_pkg::IMU_OP_THREE) |=> !gpr_wr.valid)
        else $error("word multiply wrote a general register");
    gpr_pulse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        gpr_wr.valid |=> !gpr_wr.valid)
        else $error("register write longer than one cycle");
    three_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (done && op_r == imu_pkg::IMU_OP_THREE) |=>
        ($stable(upper_product_word) && $stable(bottom_product_word)))
        else $error("three-operand op touched the pair");
    upper_only_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_upper) |=> $stable(bottom_product_word))
        else $error("upper write changed bottom word");
    bottom_only_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (start && dec_bottom) |=> $stable(upper_product_word))
        else $error("bottom write changed upper word");
endmodule : imu_top

// ---- test/imu_pipe_model.sv ----
`timescale 1ns/1ps
// Issuing side of the core pipeline
module imu_pipe_model (
    // Clock
    input wire logic sys_clk,
    // Issue
    output logic issue_valid,
    output imu_pkg::imu_issue_s issue,
    input wire logic issue_ready
);
    // No overflow input exists; software tests products itself
    initial begin
        issue_valid = 1'b0;
        issue = '0;
    end
    // Results are read back before the next issue
    task send(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b);
        logic r;
        @(posedge sys_clk);
        #1 issue_valid = 1'b1;
        issue = '{ins, a, b};
        do begin
            #3 r = issue_ready;
            @(posedge sys_clk);
        end while (!r);
        #1 issue_valid = 1'b0;
        // Stale operands must not look like the last ones
        issue = ~issue;
    endtask : send
endmodule : imu_pipe_model

// ---- test/imu_bench.sv ----
`timescale 1ns/1ps
module imu_bench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic issue_valid, issue_ready, read_stall, busy;
    logic rd_upper = 1'b0, rd_bottom = 1'b0, rd_gpr = 1'b0;
    logic [4:0] rd_gpr_index = 5'h03;
    logic [31:0] upper_product_word, bottom_product_word;
    imu_pkg::imu_issue_s issue;
    imu_pkg::imu_gpr_wr_s gpr_wr;
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    always #2.5 sys_clk = ~sys_clk;
    imu_top i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .issue_valid(issue_valid),
        .issue(issue), .issue_ready(issue_ready), .rd_upper(rd_upper),
        .rd_bottom(rd_bottom), .rd_gpr(rd_gpr), .rd_gpr_index(rd_gpr_index),
        .read_stall(read_stall), .upper_product_word(upper_product_word),
        .bottom_product_word(bottom_product_word), .gpr_wr(gpr_wr), .busy(busy));
    imu_pipe_model i_pipe (.sys_clk(sys_clk), .issue_valid(issue_valid),
        .issue(issue), .issue_ready(issue_ready));
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [31:0] ins(logic [5:0] op, logic [4:0] rd, logic [5:0] fn);
        return {op, 10'h001, rd, 5'h00, fn};
    endfunction : ins
    // Issue, then read the pending result on every busy cycle
    task run(input logic [31:0] i, a, b, input int lat, input logic ru, rg);
        i_pipe.send(i, a, b);
        n = 0;
        rd_upper = ru;
        rd_gpr = rg;
        while (busy === 1'b1 && n < 9) begin
            #1 chk("read_stall", 64'h1, read_stall);
            @(posedge sys_clk);
            #1 n++;
        end
        rd_upper = 1'b0;
        rd_gpr = 1'b0;
        chk("busy cycles", 64'(lat), 64'(n));
    endtask : run
    task summarize;
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        #20000;
        error_cnt++;
        summarize();
    end
    initial begin
        logic [31:0] a, b;
        logic [63:0] p;
        repeat (16) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        chk("ready at reset", 64'h1, issue_ready);
        chk("pair at reset", 64'h0, {upper_product_word, bottom_product_word});
        // Negative by top-bit-set operands, longest latency
        a = 32'hFFFF_FFF9;
        b = 32'h8000_0003;
        p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
        run(ins(6'h00, 5'h00, imu_pkg::FN_SIGNED_MUL), a, b, 4, 1'b1, 1'b0);
        chk("upper signed", p[63:32], upper_product_word);
        chk("bottom signed", p[31:0], bottom_product_word);
        b = 32'h0000_0300;
        p = {32'h0, a} * {32'h0, b};
        run(ins(6'h00, 5'h00, imu_pkg::FN_UNSIGNED_MUL), a, b, 2, 1'b1, 1'b0);
        chk("pair unsigned", p, {upper_product_word, bottom_product_word});
        run(ins(6'h1C, 5'h03, imu_pkg::FN_THREE_OP_MUL), 32'h1234_5678, 32'h9, 1, 1'b0, 1'b1);
        chk("gpr_wr", {1'b1, 5'h03, 32'hA3D7_0A38}, gpr_wr);
        chk("pair after three-op", p, {upper_product_word, bottom_product_word});
        run(ins(6'h00, 5'h00, imu_pkg::FN_UPPER_WRITE), 32'hA5A5_0001, 32'h0, 0, 1'b0, 1'b0);
        chk("upper write", 64'hA5A5_0001, upper_product_word);
        run(ins(6'h00, 5'h00, imu_pkg::FN_BOTTOM_WRITE), 32'h0F0F_0002, 32'h0, 0, 1'b0, 1'b0);
        chk("bottom write", 64'h0F0F_0002, bottom_product_word);
        // Nonzero bits 15..6 must not start a multiply
        run(ins(6'h00, 5'h01, imu_pkg::FN_SIGNED_MUL), a, b, 0, 1'b0, 1'b0);
        chk("pair kept", {32'hA5A5_0001, 32'h0F0F_0002},
            {upper_product_word, bottom_product_word});
        summarize();
    end
endmodule : imu_bench
